// *** lts_pkg.sv ***
// lts_pkg: constants and types of the time sync and firing stamp block
// assumes a single 25 MHz system clock domain
package lts_pkg;
	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int NS_PER_US = 1000;
	localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
	localparam logic [4:0] SUB_LAST = 5'(CYC_PER_US - 1);
	localparam int US_PER_SEC = 1000000;
	localparam logic [19:0] USEC_LAST = 20'(US_PER_SEC - 1);
	localparam int LOCK_TMO_US_DEF = 1500000;
	// -------------------------------------------------------------
	// block and channel offsets in ns
	// -------------------------------------------------------------
	localparam int NS_BLK_BASE = 5632;
	localparam int NS_BLK_STEP = 50000;
	localparam int NS_CH_STEP = 3024;
	localparam int NS_CH_BASE = 368;
	localparam logic [2:0] RND_LAST_SGL = 3'h7;
	localparam logic [2:0] RND_LAST_DUAL = 3'h3;
	// -------------------------------------------------------------
	// register map
	// -------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_INTV = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_SEC = 8'h0C;
	localparam logic [7:0] OFS_USEC = 8'h10;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	localparam logic [7:0] OFS_QRY = 8'h1C;
	localparam logic [7:0] OFS_QRY_NS = 8'h20;
	localparam int CB_PTP = 0;
	localparam int CB_GGA = 1;
	localparam int CB_PLR = 2;
	localparam int CB_AZI = 3;
	localparam int CB_DUAL = 4;
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [31:0] INTV_RST = 32'h00000000;
	localparam logic [31:0] SEC_EPOCH = 32'h00000000;
	localparam int IB_TICK = 0;
	localparam int IB_TRIG = 1;
	localparam int IB_NLOST = 2;
	localparam int IB_PLOST = 3;
	localparam int IRQ_W = 4;
	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {LK_UNLOCKED, LK_LOCKED, LK_LOST} lts_lock_t;
	typedef enum logic [1:0] {PTP_FREE, PTP_TRACK, PTP_LOCKED, PTP_FROZEN} lts_ptp_t;
endpackage : lts_pkg

// *** lts_time_sync.sv ***
// lts_time_sync: absolute time keeping, lock tracking, firing triggers
// assumes parsed sentence, ptp time and azimuth come from logic on SYS_CLK
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Function
// - time source chosen by software: satellite or ptp
// - sentence type selectable, pulse and sentence used
// - status packet on every internal tick in satellite mode
// - unlocked: count seconds from virtual epoch
// - locked: load previous sentence time plus one
// - pulse lock required gates seconds sync
// - sentence lost: count on from last time
// - pulse locked: tick aligned to pulse edge
// - pulse unlocked or lost: free running tick
// - ptp mode: no status packets
// - ptp: virtual, master time, or drift
// - ptp time taken without local correction
// - trigger on time or azimuth interval
// - rounds per packet follow return mode
// - packet time is last block trigger time
// - single return block start offsets
// - dual return paired block start offsets
// - channel firing offset per channel index
module lts_time_sync #(
	parameter int LOCK_TMO_US = lts_pkg::LOCK_TMO_US_DEF
) (
	// clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [31:0] RD_DATA,
	output logic IRQ,
	// satellite receiver
	input wire logic PPS_IN,
	input wire logic NMEA_VLD,
	input wire logic NMEA_FIX,
	input wire logic [31:0] NMEA_SEC,
	output logic PARSE_GGA,
	// ptp slave engine
	input wire logic PTP_VLD,
	input wire logic [1:0] PTP_STATE,
	input wire logic [31:0] PTP_SEC,
	input wire logic [19:0] PTP_USEC,
	// rotor position
	input wire logic [15:0] AZIMUTH,
	// firing and packet outputs
	output logic FIRE_TRIG,
	output logic GPS_PKT,
	output logic STAMP_VLD,
	output logic [31:0] STAMP_SEC,
	output logic [19:0] STAMP_USEC
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	// -------------------------------------------------------------
	// functions
	// -------------------------------------------------------------
	function automatic lts_pkg::lts_lock_t lts_lock_step(input lts_pkg::lts_lock_t st,
			input logic arrive, input logic expired);
		lts_pkg::lts_lock_t nx;
		nx = st;
		unique case (st)
			lts_pkg::LK_UNLOCKED: nx = arrive ? lts_pkg::LK_LOCKED : lts_pkg::LK_UNLOCKED;
			lts_pkg::LK_LOCKED: nx = expired ? lts_pkg::LK_LOST : lts_pkg::LK_LOCKED;
			lts_pkg::LK_LOST: nx = arrive ? lts_pkg::LK_LOCKED : lts_pkg::LK_LOST;
			default: nx = lts_pkg::LK_UNLOCKED;
		endcase
		return nx;
	endfunction : lts_lock_step

	function automatic logic [31:0] lts_fire_ofs(input logic [2:0] blk, input logic [3:0] ch,
			input logic dual);
		logic [2:0] k;
		k = dual ? {1'b0, ~blk[2:1]} : ~blk;
		return 32'(lts_pkg::NS_BLK_BASE) - 32'(lts_pkg::NS_BLK_STEP) * {29'h0, k}
			+ 32'(lts_pkg::NS_CH_STEP) * {28'h0, ch} + 32'(lts_pkg::NS_CH_BASE);
	endfunction : lts_fire_ofs

	// -------------------------------------------------------------
	// declarations
	// -------------------------------------------------------------
	logic pps_s1_r, pps_s2_r, pps_s3_r;
	logic [4:0] ctrl_r;
	logic [31:0] intv_r;
	localparam int IRQ_W_L = lts_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irq_stat_r;
	logic [IRQ_W_L-1:0] irq_mask_r;
	logic [IRQ_W_L-1:0] irq_ev;
	logic [IRQ_W_L-1:0] irq_clr;
	logic [6:0] qry_r;
	logic [4:0] sub_r;
	logic [19:0] usec_r;
	logic [31:0] sec_r;
	logic [31:0] nmea_sec_r;
	logic [20:0] nmea_age_r, pps_age_r;
	lts_pkg::lts_lock_t nmea_st_r, pps_st_r, nmea_st_nxt, pps_st_nxt;
	logic [31:0] tcnt_r;
	logic [15:0] az_prev_r;
	logic [31:0] az_acc_r, az_sum;
	logic [2:0] rnd_r;
	logic [31:0] rd_nxt;
	logic src_ptp, pps_rise, us_pls, tick, pps_align, nmea_in, gps_sync, ptp_trk;
	logic trig, rnd_last;
	lts_pkg::lts_ptp_t ptp_st;

	assign src_ptp = ctrl_r[lts_pkg::CB_PTP];
	assign ptp_st = lts_pkg::lts_ptp_t'(PTP_STATE);
	assign ptp_trk = ptp_st == lts_pkg::PTP_TRACK || ptp_st == lts_pkg::PTP_LOCKED;

	// -------------------------------------------------------------
	// pulse synchroniser
	// -------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pps_s1_r <= 1'b0;
			pps_s2_r <= 1'b0;
			pps_s3_r <= 1'b0;
		end else begin
			pps_s1_r <= PPS_IN;
			pps_s2_r <= pps_s1_r;
			pps_s3_r <= pps_s2_r;
		end
	end
	assign pps_rise = pps_s2_r && !pps_s3_r;

	// -------------------------------------------------------------
	// lock tracking
	// -------------------------------------------------------------
	assign nmea_in = NMEA_VLD && NMEA_FIX;
	assign nmea_st_nxt = lts_lock_step(nmea_st_r, nmea_in,
		!nmea_in && nmea_age_r >= 21'(LOCK_TMO_US));
	assign pps_st_nxt = lts_lock_step(pps_st_r, pps_rise,
		!pps_rise && pps_age_r >= 21'(LOCK_TMO_US));

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			nmea_st_r <= lts_pkg::LK_UNLOCKED;
			pps_st_r <= lts_pkg::LK_UNLOCKED;
			nmea_age_r <= 21'h00000;
			pps_age_r <= 21'h00000;
			nmea_sec_r <= lts_pkg::SEC_EPOCH;
		end else begin
			nmea_st_r <= nmea_st_nxt;
			pps_st_r <= pps_st_nxt;
			if (nmea_in) begin
				nmea_age_r <= 21'h00000;
				nmea_sec_r <= NMEA_SEC;
			end else if (us_pls && !(&nmea_age_r)) begin
				nmea_age_r <= nmea_age_r + 21'h00001;
			end
			if (pps_rise)
				pps_age_r <= 21'h00000;
			else if (us_pls && !(&pps_age_r))
				pps_age_r <= pps_age_r + 21'h00001;
		end
	end

	// -------------------------------------------------------------
	// time base
	// -------------------------------------------------------------
	assign us_pls = sub_r == lts_pkg::SUB_LAST;
	assign pps_align = !src_ptp && pps_st_r == lts_pkg::LK_LOCKED && pps_rise;
	assign tick = pps_align || (us_pls && usec_r == lts_pkg::USEC_LAST);
	assign gps_sync = nmea_st_r == lts_pkg::LK_LOCKED
		&& (!ctrl_r[lts_pkg::CB_PLR] || pps_st_r == lts_pkg::LK_LOCKED);

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			sub_r <= 5'h00;
			usec_r <= 20'h00000;
			sec_r <= lts_pkg::SEC_EPOCH;
		end else if (src_ptp && PTP_VLD && ptp_trk) begin
			sub_r <= 5'h00;
			usec_r <= PTP_USEC;
			sec_r <= PTP_SEC;
		end else begin
			sub_r <= (us_pls || pps_align) ? 5'h00 : sub_r + 5'h01;
			if (tick)
				usec_r <= 20'h00000;
			else if (us_pls)
				usec_r <= usec_r + 20'h00001;
			if (tick && !src_ptp && gps_sync)
				sec_r <= nmea_sec_r + 32'h00000001;
			else if (tick)
				sec_r <= sec_r + 32'h00000001;
		end
	end

	// -------------------------------------------------------------
	// firing trigger
	// -------------------------------------------------------------
	assign az_sum = az_acc_r + {16'h0000, AZIMUTH - az_prev_r};
	assign trig = intv_r != 32'h00000000 && (ctrl_r[lts_pkg::CB_AZI]
		? az_sum >= intv_r : us_pls && tcnt_r >= intv_r - 32'h00000001);
	assign rnd_last = rnd_r == (ctrl_r[lts_pkg::CB_DUAL]
		? lts_pkg::RND_LAST_DUAL : lts_pkg::RND_LAST_SGL);

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			tcnt_r <= 32'h00000000;
			az_prev_r <= 16'h0000;
			az_acc_r <= 32'h00000000;
		end else begin
			az_prev_r <= AZIMUTH;
			if (!ctrl_r[lts_pkg::CB_AZI])
				az_acc_r <= 32'h00000000;
			else
				az_acc_r <= trig ? az_sum - intv_r : az_sum;
			if (ctrl_r[lts_pkg::CB_AZI] || trig)
				tcnt_r <= 32'h00000000;
			else if (us_pls)
				tcnt_r <= tcnt_r + 32'h00000001;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rnd_r <= 3'h0;
			FIRE_TRIG <= 1'b0;
			GPS_PKT <= 1'b0;
			STAMP_VLD <= 1'b0;
			STAMP_SEC <= 32'h00000000;
			STAMP_USEC <= 20'h00000;
		end else begin
			FIRE_TRIG <= trig;
			GPS_PKT <= tick && !src_ptp;
			STAMP_VLD <= trig && rnd_last;
			if (trig)
				rnd_r <= rnd_last ? 3'h0 : rnd_r + 3'h1;
			if (trig && rnd_last) begin
				STAMP_SEC <= sec_r;
				STAMP_USEC <= usec_r;
			end
		end
	end

	// -------------------------------------------------------------
	// registers and interrupt
	// -------------------------------------------------------------
	assign irq_ev = {pps_st_r == lts_pkg::LK_LOCKED && pps_st_nxt == lts_pkg::LK_LOST,
		nmea_st_r == lts_pkg::LK_LOCKED && nmea_st_nxt == lts_pkg::LK_LOST, trig, tick};
	assign irq_clr = (WR_EN && ADDR == lts_pkg::OFS_IRQ_STAT) ? WR_DATA[IRQ_W_L-1:0] : '0;

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl_r <= lts_pkg::CTRL_RST;
			intv_r <= lts_pkg::INTV_RST;
			irq_mask_r <= '0;
			irq_stat_r <= '0;
			qry_r <= 7'h00;
			IRQ <= 1'b0;
			PARSE_GGA <= 1'b0;
		end else begin
			if (WR_EN && ADDR == lts_pkg::OFS_CTRL)
				ctrl_r <= WR_DATA[4:0];
			if (WR_EN && ADDR == lts_pkg::OFS_INTV)
				intv_r <= WR_DATA;
			if (WR_EN && ADDR == lts_pkg::OFS_IRQ_MASK)
				irq_mask_r <= WR_DATA[IRQ_W_L-1:0];
			if (WR_EN && ADDR == lts_pkg::OFS_QRY)
				qry_r <= WR_DATA[6:0];
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev;
			IRQ <= |(irq_stat_r & irq_mask_r);
			PARSE_GGA <= ctrl_r[lts_pkg::CB_GGA];
		end
	end

	always_comb begin
		rd_nxt = 32'h00000000;
		unique case (ADDR)
			lts_pkg::OFS_CTRL: rd_nxt = {27'h0, ctrl_r};
			lts_pkg::OFS_INTV: rd_nxt = intv_r;
			lts_pkg::OFS_STAT: rd_nxt = {26'h0, PTP_STATE, 2'(pps_st_r), 2'(nmea_st_r)};
			lts_pkg::OFS_SEC: rd_nxt = sec_r;
			lts_pkg::OFS_USEC: rd_nxt = {12'h000, usec_r};
			lts_pkg::OFS_IRQ_STAT: rd_nxt = {28'h0, irq_stat_r};
			lts_pkg::OFS_IRQ_MASK: rd_nxt = {28'h0, irq_mask_r};
			lts_pkg::OFS_QRY: rd_nxt = {25'h0, qry_r};
			lts_pkg::OFS_QRY_NS: rd_nxt = lts_fire_ofs(qry_r[2:0], qry_r[6:3],
				ctrl_r[lts_pkg::CB_DUAL]);
			default: rd_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N)
			RD_DATA <= 32'h00000000;
		else
			RD_DATA <= RD_EN ? rd_nxt : 32'h00000000;
	end

	// -------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------
	AST_GPS_PKT_TICK: assert property (tick && !src_ptp |=> GPS_PKT)
		else $error("status packet missing at tick");
	AST_PTP_NO_PKT: assert property (src_ptp && $past(src_ptp) |-> !GPS_PKT)
		else $error("status packet in ptp mode");
	AST_SYNC_LOAD: assert property (tick && !src_ptp && gps_sync
		|=> sec_r == $past(nmea_sec_r) + 32'h00000001)
		else $error("seconds not loaded from sentence");
	AST_PLR_HOLD: assert property (tick && !src_ptp && ctrl_r[lts_pkg::CB_PLR]
		&& pps_st_r != lts_pkg::LK_LOCKED |=> sec_r == $past(sec_r) + 32'h00000001)
		else $error("seconds synced without pulse lock");
	AST_PPS_ALIGN: assert property (pps_align |=> usec_r == 20'h00000
		&& sub_r == 5'h00 ##0 GPS_PKT)
		else $error("tick not aligned to pulse");
	AST_PTP_LOAD: assert property (src_ptp && PTP_VLD && ptp_trk
		|=> sec_r == $past(PTP_SEC) && usec_r == $past(PTP_USEC))
		else $error("ptp time not taken");
	AST_PTP_FREE: assert property (src_ptp && !PTP_VLD && tick
		|=> sec_r == $past(sec_r) + 32'h00000001)
		else $error("ptp free run not counting");
	AST_STAMP: assert property (trig && rnd_last
		|=> STAMP_VLD && FIRE_TRIG && STAMP_SEC == $past(sec_r))
		else $error("packet stamp not trigger time");
	AST_NMEA_LOST: assert property (nmea_st_r == lts_pkg::LK_LOCKED && !nmea_in
		&& nmea_age_r >= 21'(LOCK_TMO_US) |=> nmea_st_r == lts_pkg::LK_LOST)
		else $error("sentence lock not dropped");
	AST_IRQ_LEVEL: assert property (|(irq_stat_r & irq_mask_r) |=> IRQ)
		else $error("interrupt not raised");
	AST_PPS_LOST: assert property (pps_st_r == lts_pkg::LK_LOCKED && !pps_rise
		&& pps_age_r >= 21'(LOCK_TMO_US) |=> pps_st_r == lts_pkg::LK_LOST)
		else $error("pulse lock not dropped");
	AST_FIRE: assert property (trig |=> FIRE_TRIG)
		else $error("firing trigger missing");
	AST_ROUNDS: assert property (trig && !rnd_last |=> !STAMP_VLD)
		else $error("stamp before last round");
	AST_EV_WINS: assert property (irq_ev[lts_pkg::IB_TRIG] |=> irq_stat_r[lts_pkg::IB_TRIG])
		else $error("trigger event lost to clear");
	COV_AZI_TRIG: cover property (trig && ctrl_r[lts_pkg::CB_AZI]);
	COV_SYNC: cover property (tick && !src_ptp && gps_sync);
	COV_ALIGN: cover property (pps_align);
	COV_PTP: cover property (src_ptp && PTP_VLD && ptp_trk);
	COV_DUAL_STAMP: cover property (trig && rnd_last && ctrl_r[lts_pkg::CB_DUAL]);
endmodule : lts_time_sync
`default_nettype wire

// *** lts_partner.sv ***
// lts_partner: satellite receiver and ptp master model
// assumes the block's clock; one pulse and one sentence every PERIOD cycles
`timescale 1ns/100ps
`default_nettype none
module lts_partner #(
	parameter int PERIOD = 100
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// source enables
	input wire logic gps_en,
	input wire logic ptp_en,
	// satellite side
	output logic pps,
	output logic nmea_vld,
	output logic nmea_fix,
	output logic [31:0] nmea_sec,
	// ptp side
	output logic ptp_vld,
	output logic [31:0] ptp_sec,
	output logic [19:0] ptp_usec
);
	localparam logic [31:0] PTP_T = 32'h00012345;
	logic [7:0] cnt_r;
	logic [31:0] sec_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			sec_r <= 32'h00000100;
		end else begin
			cnt_r <= (cnt_r == 8'(PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
			if (nmea_vld) begin
				sec_r <= sec_r + 32'h00000001;
			end
		end
	end
	// pulse, then sentence mid-period; idle data lines inverted
	assign pps = gps_en && (cnt_r < 8'h05);
	assign nmea_vld = gps_en && (cnt_r == 8'h32);
	assign nmea_fix = nmea_vld;
	assign nmea_sec = nmea_vld ? sec_r : ~sec_r;
	// master time with fixed seconds
	assign ptp_vld = ptp_en && (cnt_r == 8'h0A);
	assign ptp_sec = ptp_vld ? PTP_T : ~PTP_T;
	assign ptp_usec = ptp_vld ? 20'h00010 : 20'hFFFEF;
endmodule : lts_partner
`default_nettype wire

// *** tb.sv ***
// tb: register-level test of lts_time_sync
// assumes lts_partner as receiver and master, lock timeout shortened to 5 us
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic SYS_CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WR_DATA = 32'h00000000;
	logic WR_EN = 1'b0;
	logic RD_EN = 1'b0;
	logic [1:0] PTP_STATE = 2'h0;
	logic [15:0] AZIMUTH = 16'h0000;
	logic [31:0] RD_DATA, NMEA_SEC, PTP_SEC, STAMP_SEC, rdat;
	logic [19:0] PTP_USEC, STAMP_USEC, u_last, d_us;
	logic IRQ, PPS_IN, NMEA_VLD, NMEA_FIX, PARSE_GGA, PTP_VLD, FIRE_TRIG, GPS_PKT, STAMP_VLD;
	logic gps_en = 1'b0;
	logic ptp_en = 1'b0;
	logic az_run = 1'b0;
	int n_mismatch = 0;
	int total_checks = 0;
	int n_fire = 0, n_pkt = 0, n_stamp = 0, d_fire = 0, f_last = 0, cyc = 0, p_last = 0, d_pkt = 0;
	int k;
	always #20 SYS_CLK = ~SYS_CLK;
	lts_time_sync #(.LOCK_TMO_US(5)) lts_time_sync_i (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N),
		.ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA),
		.IRQ(IRQ), .PPS_IN(PPS_IN), .NMEA_VLD(NMEA_VLD), .NMEA_FIX(NMEA_FIX),
		.NMEA_SEC(NMEA_SEC), .PARSE_GGA(PARSE_GGA), .PTP_VLD(PTP_VLD), .PTP_STATE(PTP_STATE),
		.PTP_SEC(PTP_SEC), .PTP_USEC(PTP_USEC), .AZIMUTH(AZIMUTH), .FIRE_TRIG(FIRE_TRIG),
		.GPS_PKT(GPS_PKT), .STAMP_VLD(STAMP_VLD), .STAMP_SEC(STAMP_SEC), .STAMP_USEC(STAMP_USEC));
	lts_partner #(.PERIOD(100)) lts_partner_i (.clk(SYS_CLK), .rst_n(RESET_N), .gps_en(gps_en),
		.ptp_en(ptp_en), .pps(PPS_IN), .nmea_vld(NMEA_VLD), .nmea_fix(NMEA_FIX),
		.nmea_sec(NMEA_SEC), .ptp_vld(PTP_VLD), .ptp_sec(PTP_SEC), .ptp_usec(PTP_USEC));
	// -------------------------------------------------------------
	// output monitor and rotor
	// -------------------------------------------------------------
	always @(posedge SYS_CLK) begin
		cyc++;
		if (FIRE_TRIG === 1'b1) n_fire++;
		if (GPS_PKT === 1'b1) begin
			n_pkt++;
			d_pkt = cyc - p_last;
			p_last = cyc;
		end
		if (STAMP_VLD === 1'b1) begin
			n_stamp++;
			d_fire = n_fire - f_last;
			f_last = n_fire;
			d_us = STAMP_USEC - u_last;
			u_last = STAMP_USEC;
		end
		if (az_run) AZIMUTH <= AZIMUTH + 16'h000A;
	end
	// -------------------------------------------------------------
	// tasks
	// -------------------------------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : close_out
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge SYS_CLK);
		ADDR <= a;
		WR_DATA <= d;
		WR_EN <= 1'b1;
		@(posedge SYS_CLK);
		WR_EN <= 1'b0;
	endtask : wr
	task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		@(posedge SYS_CLK);
		ADDR <= a;
		RD_EN <= 1'b1;
		@(posedge SYS_CLK);
		RD_EN <= 1'b0;
		@(negedge SYS_CLK);
		rdat = RD_DATA;
		chk(nm, rdat, exp);
	endtask : rd_chk
	task automatic wait_inc(ref int c, input int m, input string nm);
		int c0;
		c0 = c;
		for (int i = 0; i < 4000 && c < c0 + m; i++) @(negedge SYS_CLK);
		if (c < c0 + m) begin
			n_mismatch++;
			$display("mismatch %s wait expected event seen none", nm);
			close_out();
		end
	endtask : wait_inc
	task automatic run_trig(input logic [31:0] ctl, input logic [31:0] intv, input int ef,
			input bit cu);
		wr(lts_pkg::OFS_CTRL, ctl);
		wr(lts_pkg::OFS_INTV, intv);
		wait_inc(n_stamp, 2, "stamp");
		chk("rounds per stamp", 32'(d_fire), 32'(ef));
		chk("stamp seconds", STAMP_SEC, lts_partner_i.PTP_T);
		if (cu) chk("stamp step", {12'h000, d_us}, 32'(ef) * intv);
		wr(lts_pkg::OFS_INTV, 32'h00000000);
	endtask : run_trig
	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		repeat (8) @(posedge SYS_CLK);
		RESET_N <= 1'b1;
		rd_chk("ctrl", lts_pkg::OFS_CTRL, {27'h0, lts_pkg::CTRL_RST});
		rd_chk("intv", lts_pkg::OFS_INTV, lts_pkg::INTV_RST);
		rd_chk("epoch", lts_pkg::OFS_SEC, lts_pkg::SEC_EPOCH);
		rd_chk("unmapped", 8'h3C, 32'h00000000);
		chk("rmc select", {31'h0, PARSE_GGA}, 32'h00000000);
		wr(lts_pkg::OFS_CTRL, 32'h00000002);
		repeat (2) @(posedge SYS_CLK);
		chk("gga select", {31'h0, PARSE_GGA}, 32'h00000001);
		wr(lts_pkg::OFS_CTRL, 32'h00000004);
		gps_en <= 1'b1;
		repeat (600) @(posedge SYS_CLK);
		rd_chk("both locked", lts_pkg::OFS_STAT, 32'h00000005);
		wait_inc(n_pkt, 1, "tick");
		rd_chk("synced seconds", lts_pkg::OFS_SEC, lts_partner_i.sec_r);
		wait_inc(n_pkt, 1, "tick");
		chk("tick spacing", 32'(d_pkt), 32'h00000064);
		k = n_pkt;
		repeat (920) @(posedge SYS_CLK);
		chk("status packets", 32'(n_pkt - k), 32'h00000009);
		gps_en <= 1'b0;
		repeat (400) @(posedge SYS_CLK);
		rd_chk("both lost", lts_pkg::OFS_STAT, 32'h0000000A);
		rd_chk("drift seconds", lts_pkg::OFS_SEC, lts_partner_i.sec_r);
		chk("irq masked", {31'h0, IRQ}, 32'h00000000);
		wr(lts_pkg::OFS_IRQ_MASK, 32'h0000000C);
		repeat (2) @(posedge SYS_CLK);
		chk("irq raised", {31'h0, IRQ}, 32'h00000001);
		wr(lts_pkg::OFS_IRQ_STAT, 32'h0000000F);
		repeat (2) @(posedge SYS_CLK);
		chk("irq cleared", {31'h0, IRQ}, 32'h00000000);
		rd_chk("lost bits clear", lts_pkg::OFS_IRQ_STAT, 32'h00000000);
		PTP_STATE <= 2'h2;
		ptp_en <= 1'b1;
		gps_en <= 1'b1;
		wr(lts_pkg::OFS_CTRL, 32'h00000001);
		repeat (300) @(posedge SYS_CLK);
		rd_chk("master seconds", lts_pkg::OFS_SEC, lts_partner_i.PTP_T);
		k = n_pkt;
		PTP_STATE <= 2'h3;
		repeat (300) @(posedge SYS_CLK);
		chk("no status packet", 32'(n_pkt - k), 32'h00000000);
		rd_chk("frozen seconds", lts_pkg::OFS_SEC, lts_partner_i.PTP_T);
		ptp_en <= 1'b0;
		gps_en <= 1'b0;
		run_trig(32'h00000000, 32'h00000003, 8, 1'b1);
		run_trig(32'h00000010, 32'h00000003, 4, 1'b1);
		az_run <= 1'b1;
		run_trig(32'h00000008, 32'h00000064, 8, 1'b0);
		az_run <= 1'b0;
		for (int n = 1; n <= 8; n++) begin
			for (int d = 0; d < 2; d++) begin
				wr(lts_pkg::OFS_CTRL, d ? 32'h00000010 : 32'h00000000);
				wr(lts_pkg::OFS_QRY, {25'h0, 4'(2 * n - d - 1), 3'(n - 1)});
				k = d ? (8 - n) / 2 : 8 - n;
				k = lts_pkg::NS_BLK_BASE - lts_pkg::NS_BLK_STEP * k + lts_pkg::NS_CH_BASE
					+ lts_pkg::NS_CH_STEP * (2 * n - d - 1);
				rd_chk("firing offset", lts_pkg::OFS_QRY_NS, 32'(k));
			end
		end
		close_out();
	end
endmodule : tb
`default_nettype wire
